/* hdl/chdm_consts.svh */
// chdm_consts.svh: offsets, field positions and reset values of the calendar block
// assumes inclusion by its bare name from hdl/
`ifndef CHDM_CONSTS_SVH
`define CHDM_CONSTS_SVH

`define CHDM_ADDR_HOUR       8'h0A
`define CHDM_ADDR_DAY        8'h0B
`define CHDM_ADDR_WDAY       8'h0C
`define CHDM_ADDR_MONTH      8'h0D
`define CHDM_HOUR_FMT_BIT    6
`define CHDM_HOUR_PM_BIT     5
`define CHDM_RST_HOUR        8'h00
`define CHDM_RST_DAY         8'h01
`define CHDM_RST_WDAY        8'h01
`define CHDM_RST_MONTH       8'h01
`define CHDM_FEB             5'h02
`define CHDM_DEC             5'h12

`endif

/* hdl/chdm_pkg.sv */
// chdm_pkg.sv: types of the calendar block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package chdm_pkg;
  typedef logic [7:0] chdm_bcd_t;
  typedef enum logic [1:0] {
    CHDM_SEL_HOUR,
    CHDM_SEL_DAY,
    CHDM_SEL_WDAY,
    CHDM_SEL_MONTH
  } chdm_sel_t;
endpackage
`default_nettype wire

/* hdl/chdm_bcd_inc.sv */
// chdm_bcd_inc.sv: combinational BCD increment with wrap to a given value
// assumes inputs are valid BCD below or equal to the limit
`timescale 1ns/1ps
`default_nettype none
module chdm_bcd_inc
  import chdm_pkg::*;
(
  // operand
  input  wire logic      [7:0] value_i,
  input  wire logic      [7:0] limit_i,
  input  wire logic      [7:0] wrap_i,
  // result
  output logic           [7:0] next_o,
  output logic                 wrapped_o
);
  always_comb begin
    wrapped_o = (value_i >= limit_i);
    if (wrapped_o) begin
      next_o = wrap_i;
    end else if (value_i[3:0] == 4'h9) begin
      next_o = {value_i[7:4] + 4'h1, 4'h0};
    end else begin
      next_o = {value_i[7:4], value_i[3:0] + 4'h1};
    end
  end
endmodule
`default_nettype wire

/* hdl/chdm_calendar.sv */
// chdm_calendar.sv: hour, day-of-month, weekday and month registers with carry chain
// assumes hour_tick_i from the minutes stage, year_i from the years stage, one bus write per cycle
`timescale 1ns/1ps
`default_nettype none
`include "chdm_consts.svh"
module chdm_calendar
  import chdm_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // carry in from minutes and year value
  input  wire logic       hour_tick_i,
  input  wire logic [7:0] year_i,
  // register access
  input  wire logic [7:0] addr_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] rd_data_o,
  // carry out to years
  output logic            year_tick_o
);
  chdm_bcd_t hour;
  chdm_bcd_t day;
  chdm_bcd_t wday;
  chdm_bcd_t month;
  chdm_bcd_t next_hour;
  chdm_bcd_t next_day;
  chdm_bcd_t next_wday;
  chdm_bcd_t next_month;
  chdm_bcd_t next_rd_data;
  logic      next_year_tick;
  logic      year_tick;
  logic      day_end;
  logic      month_end;
  logic      day_wrap;
  logic      month_wrap;
  logic      twelve_mode;
  logic      pm;
  logic [7:0] hour_body;
  logic [7:0] hour_inc;
  logic [7:0] hour_limit;
  logic [7:0] hour_wrapv;
  logic [7:0] day_inc;
  logic [7:0] month_inc;
  logic [7:0] month_len;
  chdm_sel_t bus_sel;
  logic      bus_hit;
  logic      wr_hour;
  logic      wr_day;
  logic      wr_wday;
  logic      wr_month;

  function automatic logic [7:0] days_in_month(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    // an odd tens digit adds ten, which is two modulo four
    leap = ((y[4] ? 2'h2 : 2'h0) + y[1:0]) == 2'h0;
    if (m == `CHDM_FEB) begin
      days_in_month = leap ? 8'h29 : 8'h28;
    end else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11) begin
      days_in_month = 8'h30;
    end else begin
      days_in_month = 8'h31;
    end
  endfunction

  // register behind a bus address; meaningful only where addr_mapped is true
  function automatic chdm_sel_t addr_to_sel(input logic [7:0] a);
    case (a)
      `CHDM_ADDR_DAY:   addr_to_sel = CHDM_SEL_DAY;
      `CHDM_ADDR_WDAY:  addr_to_sel = CHDM_SEL_WDAY;
      `CHDM_ADDR_MONTH: addr_to_sel = CHDM_SEL_MONTH;
      default:          addr_to_sel = CHDM_SEL_HOUR;
    endcase
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a >= `CHDM_ADDR_HOUR) && (a <= `CHDM_ADDR_MONTH);
  endfunction

  assign twelve_mode = hour[`CHDM_HOUR_FMT_BIT];
  assign pm          = hour[`CHDM_HOUR_PM_BIT];
  assign month_len   = days_in_month(month[4:0], year_i);

  always_comb begin
    if (twelve_mode) begin
      hour_body  = {3'h0, hour[4:0]};
      hour_limit = 8'h12;
      hour_wrapv = 8'h01;
    end else begin
      hour_body  = {2'h0, hour[5:0]};
      hour_limit = 8'h23;
      hour_wrapv = 8'h00;
    end
  end

  chdm_bcd_inc u_hour (
    .value_i   (hour_body),
    .limit_i   (hour_limit),
    .wrap_i    (hour_wrapv),
    .next_o    (hour_inc),
    .wrapped_o ()
  );
  chdm_bcd_inc u_day (
    .value_i   (day),
    .limit_i   (month_len),
    .wrap_i    (8'h01),
    .next_o    (day_inc),
    .wrapped_o (day_wrap)
  );
  chdm_bcd_inc u_month (
    .value_i   (month),
    .limit_i   ({3'h0, `CHDM_DEC}),
    .wrap_i    (8'h01),
    .next_o    (month_inc),
    .wrapped_o (month_wrap)
  );

  // one decode of the bus address serves both the write strobes and the read mux
  assign bus_sel  = addr_to_sel(addr_i);
  assign bus_hit  = addr_mapped(addr_i);
  assign wr_hour  = wr_en_i && bus_hit && (bus_sel == CHDM_SEL_HOUR);
  assign wr_day   = wr_en_i && bus_hit && (bus_sel == CHDM_SEL_DAY);
  assign wr_wday  = wr_en_i && bus_hit && (bus_sel == CHDM_SEL_WDAY);
  assign wr_month = wr_en_i && bus_hit && (bus_sel == CHDM_SEL_MONTH);

  // last hour of the day: 11 PM in 12-hour form, 23 in 24-hour form
  always_comb begin
    if (twelve_mode) begin
      day_end = hour_tick_i && pm && (hour[4:0] == 5'h11);
    end else begin
      day_end = hour_tick_i && (hour[5:0] == 6'h23);
    end
    month_end = day_end && day_wrap;
  end

  // hour group: the hourly carry counts, a host write wins over a same-cycle count
  always_comb begin
    next_hour = hour;
    if (hour_tick_i) begin
      if (twelve_mode) begin
        // 11 flips AM/PM, 12 goes to 1 without flipping
        next_hour = {1'b0, 1'b1, pm ^ (hour[4:0] == 5'h11), hour_inc[4:0]};
      end else begin
        next_hour = {2'h0, hour_inc[5:0]};
      end
    end
    // written values are trusted to be valid; only bit 7 is dropped
    if (wr_hour) begin
      next_hour = {1'b0, wr_data_i[6:0]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hour <= `CHDM_RST_HOUR;
    end else begin
      hour <= next_hour;
    end
  end

  // day and weekday group: both step at the end of the day
  always_comb begin
    next_day  = day;
    next_wday = wday;
    if (day_end) begin
      next_day  = day_inc;
      // a written code of 0 also lands on 1 here
      next_wday = (wday[2:0] == 3'h7) ? 8'h01 : {5'h0, wday[2:0] + 3'h1};
    end
    if (wr_day) begin
      next_day = {2'h0, wr_data_i[5:0]};
    end
    if (wr_wday) begin
      next_wday = {5'h0, wr_data_i[2:0]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      day  <= `CHDM_RST_DAY;
      wday <= `CHDM_RST_WDAY;
    end else begin
      day  <= next_day;
      wday <= next_wday;
    end
  end

  // month group: steps when the day wraps; December wrapping carries into the year
  always_comb begin
    next_month     = month;
    next_year_tick = 1'b0;
    if (month_end) begin
      next_month     = month_inc;
      next_year_tick = month_wrap;
    end
    if (wr_month) begin
      next_month = {3'h0, wr_data_i[4:0]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      month     <= `CHDM_RST_MONTH;
      year_tick <= 1'b0;
    end else begin
      month     <= next_month;
      year_tick <= next_year_tick;
    end
  end

  // read group: the value before any same-edge write; unmapped addresses read zero
  always_comb begin
    next_rd_data = 8'h00;
    if (bus_hit) begin
      unique case (bus_sel)
        CHDM_SEL_HOUR:  next_rd_data = hour;
        CHDM_SEL_DAY:   next_rd_data = day;
        CHDM_SEL_WDAY:  next_rd_data = wday;
        CHDM_SEL_MONTH: next_rd_data = month;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end

  assign year_tick_o = year_tick;
endmodule
`default_nettype wire

/* tb/chdm_calendar_assertions.sv */
// chdm_calendar_assertions.sv: port checker for the calendar block
// assumes a bind to chdm_calendar, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module chdm_calendar_assertions (
  // watched ports
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       hour_tick_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] rd_data_o,
  input  wire logic       year_tick_o
);
  logic      [7:0] ra;
  wire logic [7:0] q = rd_data_o;
  // address whose value rd_data_o shows now
  always_ff @(posedge clock_i) ra <= rst_i ? 8'hFF : addr_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  hour_12h_a: assert property (ra == 8'h0A && q[6] |-> q[4:0] inside {[5'h01:5'h09], [5'h10:5'h12]})
    else $error("bad 12h hour");
  hour_24h_a: assert property (ra == 8'h0A && !q[6] |-> !q[7] && q[5:0] <= 6'h23 && q[3:0] <= 4'h9)
    else $error("bad 24h hour");
  day_range_a: assert property (ra == 8'h0B |-> q[7:6] == 2'h0 && q != 8'h00 && q <= 8'h31 && q[3:0] <= 4'h9)
    else $error("bad day");
  wday_range_a: assert property (ra == 8'h0C |-> q inside {[8'h01:8'h07]}) else $error("bad weekday");
  month_range_a: assert property (ra == 8'h0D |-> q inside {[8'h01:8'h09], [8'h10:8'h12]})
    else $error("bad month");
  hour_roll_a: assert property (ra == 8'h0A && q == 8'h23 && !$past(hour_tick_i) && !$past(wr_en_i)
    && hour_tick_i && !wr_en_i && addr_i == 8'h0A ##1 addr_i == 8'h0A |=> q == 8'h00) else $error("no rollover");
  ytick_pulse_a: assert property (year_tick_o |=> !year_tick_o) else $error("long year carry");
  ytick_cause_a: assert property (year_tick_o |-> $past(hour_tick_i)) else $error("stray year carry");
  cover property (year_tick_o);
  cover property (ra == 8'h0A && q[6]);
  cover property (ra == 8'h0B && q == 8'h29);
endmodule
`default_nettype wire

/* tb/chdm_host.sv */
// chdm_host.sv: host model on the register bus of the calendar block
// assumes it is called 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
module chdm_host (
  // register bus
  input  wire logic       clock_i,
  input  wire logic [7:0] rd_data_i,
  output logic      [7:0] addr_o,
  output logic            wr_en_o,
  output logic      [7:0] wr_data_o
);
  initial begin
    addr_o = 8'h00;
    wr_en_o = 1'b0;
    wr_data_o = 8'h00;
  end
  // one idle cycle after each write keeps strobes apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_o = a;
    wr_data_o = d;
    wr_en_o = 1'b1;
    @(posedge clock_i) #1 wr_en_o = 1'b0;
    @(posedge clock_i) #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_o = a;
    repeat (2) @(posedge clock_i);
    #1 d = rd_data_i;
  endtask
endmodule
`default_nettype wire

/* tb/test_chdm_calendar.sv */
// test_chdm_calendar.sv: self-checking bench for the calendar block
// assumes chdm_host as bus master and the port checker bound below
`timescale 1ns/1ps
`default_nettype none
module test_chdm_calendar;
  logic       clock_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       hour_tick_i = 1'b0;
  logic [7:0] year_i = 8'h00;
  logic [7:0] addr, wd, rd, got;
  logic       wr_en, yt;
  int         mismatches = 0;
  int         check_count = 0;
  logic [23:0] uw [5] = '{24'h0AA323, 24'h0BD515, 24'h0CFB03, 24'h0DE909, 24'h0E5500};
  logic [15:0] hr [5] = '{16'h0910, 16'h5172, 16'h7261, 16'h7152, 16'h5241};
  logic [39:0] de [7] = '{40'h2402282902, 40'h2402290103, 40'h2302280103, 40'h0002282902,
                          40'h2304300105, 40'h2309300110, 40'h1912310101};
  always #12.5 clock_i = ~clock_i;
  chdm_calendar chdm_calendar_i (.clock_i(clock_i), .rst_i(rst_i), .hour_tick_i(hour_tick_i), .year_i(year_i),
    .addr_i(addr), .wr_en_i(wr_en), .wr_data_i(wd), .rd_data_o(rd), .year_tick_o(yt));
  chdm_host chdm_host_i (.clock_i(clock_i), .rd_data_i(rd), .addr_o(addr), .wr_en_o(wr_en), .wr_data_o(wd));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    chdm_host_i.rd(a, got);
    chk(n, e, got);
  endtask
  task automatic tick();
    hour_tick_i = 1'b1;
    @(posedge clock_i) #1 hour_tick_i = 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    #1 rst_i = 1'b0;
    for (int i = 0; i < 5; i++) rdc("reset value", 8'h0A + 8'(i), (i % 4 == 0) ? 8'h00 : 8'h01);
    foreach (uw[i]) begin
      chdm_host_i.wr(uw[i][23:16], uw[i][15:8]);
      rdc("stored value", uw[i][23:16], uw[i][7:0]);
    end
    $display("reset and access test done");
    foreach (hr[i]) begin
      chdm_host_i.wr(8'h0A, hr[i][15:8]);
      tick();
      rdc("hour", 8'h0A, hr[i][7:0]);
    end
    $display("hour test done");
    foreach (de[i]) begin
      year_i = de[i][39:32];
      chdm_host_i.wr(8'h0D, de[i][31:24]);
      chdm_host_i.wr(8'h0B, de[i][23:16]);
      chdm_host_i.wr(8'h0C, 8'(i + 1));
      chdm_host_i.wr(8'h0A, 8'h23);
      rdc("hour", 8'h0A, 8'h23);
      tick();
      chk("year carry", 8'(de[i][31:24] == 8'h12), 8'(yt));
      rdc("hour", 8'h0A, 8'h00);
      rdc("day", 8'h0B, de[i][15:8]);
      rdc("month", 8'h0D, de[i][7:0]);
      rdc("weekday", 8'h0C, (i == 6) ? 8'h01 : 8'(i + 2));
    end
    $display("day end test done");
    // load non-reset values, then check that a mid-run reset restores every register
    foreach (uw[i]) chdm_host_i.wr(uw[i][23:16], uw[i][15:8]);
    rst_i = 1'b1;
    repeat (3) @(posedge clock_i);
    #1 rst_i = 1'b0;
    for (int i = 0; i < 5; i++) rdc("reset value", 8'h0A + 8'(i), (i % 4 == 0) ? 8'h00 : 8'h01);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
bind chdm_calendar chdm_calendar_assertions chdm_calendar_assertions_i (.clock_i(clock_i), .rst_i(rst_i),
  .hour_tick_i(hour_tick_i), .addr_i(addr_i), .wr_en_i(wr_en_i), .rd_data_o(rd_data_o), .year_tick_o(year_tick_o));
`default_nettype wire
